//--- rhb_dma_sink.sv
// dma-side sink model: takes header words, checks handshake stability
`default_nettype none
module rhb_dma_sink
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // header stream
  input  wire logic [31:0] hdr_data_i,
  input  wire logic        hdr_valid_i,
  input  wire logic        hdr_last_i,
  output logic             hdr_ready_o,
  // control and results
  input  wire logic        stall_i,
  output logic [319:0]     hdr_o,
  output int               n_hdr_o,
  output logic             err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int          idx;
  logic        held;
  logic [31:0] prev;

  // ready may drop at any cycle, as a busy dma path would do
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      idx         <= 0;
      n_hdr_o     <= 0;
      err_o       <= 1'b0;
      held        <= 1'b0;
      hdr_ready_o <= 1'b0;
    end
    else
    begin
      hdr_ready_o <= !stall_i;
      held        <= hdr_valid_i && !hdr_ready_o;
      prev        <= hdr_data_i;
      if (held && (!hdr_valid_i || hdr_data_i !== prev))
        err_o <= 1'b1;
      if (hdr_valid_i && hdr_ready_o)
      begin
        hdr_o[idx*32 +: 32] <= hdr_data_i;
        if (hdr_last_i !== (idx == 9))
          err_o <= 1'b1;
        idx <= (idx == 9) ? 0 : idx + 1;
        if (idx == 9)
          n_hdr_o <= n_hdr_o + 1;
      end
    end
  end
endmodule : rhb_dma_sink
`default_nettype wire

//--- rhb_pkg.sv
// package: record header layout, status bit positions and constants
`default_nettype none
package rhb_pkg;
  localparam int HDR_BYTES     = 40;
  localparam int HDR_WORDS     = 10;
  localparam int FILL_W        = 3;
  localparam int ST_RANGE_BIT  = 0;
  localparam int ST_FILL_LSB   = 1;
  localparam int ST_LOST_BEG   = 4;
  localparam int ST_LOST_MID   = 5;
  localparam int ST_LOST_END   = 6;
  localparam logic [7:0] FMT_16BIT = 8'h00;
  localparam logic [7:0] FMT_32BIT = 8'h01;
  localparam logic [3:0] WIDX_LAST = 4'h9;
  localparam logic [2:0] FILL_ZERO = 3'h0;
  localparam logic [31:0] CNT_ONE  = 32'h0000_0001;
  localparam int TIME_UNIT_PS  = 25;
  // register port offsets (word addresses)
  localparam logic [3:0] A_USER_ID  = 4'h0;
  localparam logic [3:0] A_CHANNEL  = 4'h1;
  localparam logic [3:0] A_FORMAT   = 4'h2;
  localparam logic [3:0] A_SERIAL   = 4'h3;
  localparam logic [3:0] A_PERIOD   = 4'h4;
  localparam logic [3:0] A_GP       = 4'h5;
  localparam logic [3:0] A_RECCNT   = 4'h6;
  localparam logic [3:0] A_STATUS   = 4'h7;
  localparam logic [3:0] A_TSRST    = 4'h8;
  // arbitrary neutral identity value
  localparam logic [31:0] SERIAL_RST = 32'h0000_0001;
  localparam logic [31:0] ZERO32     = 32'h0000_0000;
endpackage : rhb_pkg
`default_nettype wire

//--- rhb_status_acc.sv
// status accumulator: sticky range, peak fill, lost-data flags per record
`default_nettype none
module rhb_status_acc
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // record boundary
  input  wire logic       rec_start_i,
  input  wire logic       rec_end_i,
  // events
  input  wire logic       range_evt_i,
  input  wire logic [2:0] fill_i,
  input  wire logic       lost_beg_i,
  input  wire logic       lost_mid_i,
  input  wire logic       lost_end_i,
  // snapshot at record end
  output logic      [7:0] status_o
);
  logic       range_r;
  logic [2:0] fill_r;
  logic       lbeg_r;
  logic       lmid_r;
  logic       lend_r;
  logic [2:0] fill_nxt;

  // the start clears, but an event in the same cycle still counts
  always_comb
  begin
    fill_nxt = rec_start_i ? rhb_pkg::FILL_ZERO : fill_r;
    if (fill_i > fill_nxt)
      fill_nxt = fill_i; // R13
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      range_r <= 1'b0;
      fill_r  <= rhb_pkg::FILL_ZERO;
      lbeg_r  <= 1'b0;
      lmid_r  <= 1'b0;
      lend_r  <= 1'b0;
    end
    else
    begin
      range_r <= range_evt_i | (range_r & ~rec_start_i); // R19 R20
      fill_r  <= fill_nxt; // R12
      lbeg_r  <= lost_beg_i | (lbeg_r & ~rec_start_i); // R14 R15
      lmid_r  <= lost_mid_i | (lmid_r & ~rec_start_i); // R16
      lend_r  <= lost_end_i | (lend_r & ~rec_start_i); // R17
    end
  end

  // snapshot includes the events of the end cycle itself
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      status_o <= 8'h00;
    else if (rec_end_i)
    begin
      status_o <= 8'h00;
      status_o[rhb_pkg::ST_RANGE_BIT] <= range_evt_i |
                                         (range_r & ~rec_start_i); // R23
      status_o[rhb_pkg::ST_FILL_LSB +: rhb_pkg::FILL_W] <= fill_nxt;
      status_o[rhb_pkg::ST_LOST_BEG] <= lost_beg_i |
                                        (lbeg_r & ~rec_start_i);
      status_o[rhb_pkg::ST_LOST_MID] <= lost_mid_i |
                                        (lmid_r & ~rec_start_i);
      status_o[rhb_pkg::ST_LOST_END] <= lost_end_i |
                                        (lend_r & ~rec_start_i);
    end
  end

  property p_range_sticky;
    @(posedge clk_i) disable iff (!nrst_i)
      (range_r && !rec_start_i) |=> range_r;
  endproperty
  a_range_sticky: assert property (p_range_sticky) // R20
    else $error("range flag dropped inside a record");

  property p_range_set;
    @(posedge clk_i) disable iff (!nrst_i)
      range_evt_i |=> range_r;
  endproperty
  a_range_set: assert property (p_range_set) // R19
    else $error("range event not recorded");

  property p_fill_peak;
    @(posedge clk_i) disable iff (!nrst_i)
      (!rec_start_i) |=> (fill_r >= $past(fill_r));
  endproperty
  a_fill_peak: assert property (p_fill_peak) // R13
    else $error("peak fill level decreased within record");

  property p_lost_mid;
    @(posedge clk_i) disable iff (!nrst_i)
      (lost_mid_i && !rec_end_i) ##1 (!rec_start_i)[*2] |-> lmid_r;
  endproperty
  a_lost_mid: assert property (p_lost_mid) // R16
    else $error("middle-loss flag not held");

  property p_lost_beg;
    @(posedge clk_i) disable iff (!nrst_i)
      lost_beg_i |=> lbeg_r;
  endproperty
  a_lost_beg: assert property (p_lost_beg) // R15
    else $error("start-loss flag not set");

  property p_lost_end;
    @(posedge clk_i) disable iff (!nrst_i)
      (lost_end_i && rec_end_i) |=> status_o[rhb_pkg::ST_LOST_END];
  endproperty
  a_lost_end: assert property (p_lost_end) // R17
    else $error("end-loss missing from status");
endmodule : rhb_status_acc
`default_nettype wire

//--- rhb_top.sv
// record header builder: metadata capture and 40-byte header emission
// Functional notes
// (R1) header begins with status byte: range, fill level, lost data
// (R2) unit identifier byte comes from a software-set register
// (R3) channel byte names record source; low codes are physical inputs
// (R4) 32-bit field carries numeric part of unit serial number
// (R5) 32-bit record count from reset, plus one per captured record
// (R6) signed 32-bit sample period in 25 ps units
// (R7) unsigned 64-bit trigger time in 25 ps units
// (R8) signed 64-bit start offset from trigger, 25 ps units
// (R9) unsigned 32-bit record length, in bytes here
// (R10) 16-bit general-purpose word from a register, option-defined
// (R11) 16-bit count of timestamp counter resets
// (R12) fill level is 3 bits in eighths, 000 low, 111 high
// (R13) reported fill is the record's peak level
// (R14) buffer overflow losses set lost-data bits of that record
// (R15) distinct bit marks dropped record start; timestamp invalid
// (R16) distinct bit marks any internal gaps, regardless of count
// (R17) distinct bit marks dropped record end
// (R18) format byte: 0 is 16-bit words, 1 is 32-bit words
// (R19) range flag set if any sample over/underflowed anywhere
// (R20) range flag stays set until record end, cleared for next
// (R21) every header is exactly forty bytes
// (R22) fields packed in listed order, little-endian
// (R23) status: bit0 range, bits3:1 fill, bits6:4 begin/middle/end loss
`default_nettype none
module rhb_top
#(
  parameter int SERIAL_W = 32
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // register port
  input  wire logic  [3:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // acquisition events
  input  wire logic        rec_start_i,
  input  wire logic        rec_end_i,
  input  wire logic [63:0] trig_time_i,
  input  wire logic [63:0] start_off_i,
  input  wire logic [31:0] rec_len_i,
  input  wire logic        range_evt_i,
  input  wire logic  [2:0] fill_i,
  input  wire logic        lost_beg_i,
  input  wire logic        lost_mid_i,
  input  wire logic        lost_end_i,
  input  wire logic        ts_reset_i,
  // header stream to dma
  output logic      [31:0] hdr_data_o,
  output logic             hdr_valid_o,
  output logic             hdr_last_o,
  input  wire logic        hdr_ready_i
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } rhb_state_t;

  rhb_state_t  state_r;
  logic  [7:0] user_id_r;
  logic  [7:0] channel_r;
  logic  [7:0] format_r;
  logic [31:0] serial_r;
  logic [31:0] period_r;
  logic [15:0] gp_r;
  logic [31:0] rec_cnt_r;
  logic [15:0] ts_rst_cnt_r;
  logic [63:0] trig_time_field;
  logic [63:0] start_off_r;
  logic [31:0] len_r;
  logic  [7:0] status_w;
  logic  [7:0] stat_hold_r;
  logic  [3:0] widx_r;
  logic        end_d_r;
  logic [31:0] word_nxt;
  logic        sending_nxt;

  rhb_status_acc u_stat
  (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .rec_start_i (rec_start_i),
    .rec_end_i   (rec_end_i),
    .range_evt_i (range_evt_i),
    .fill_i      (fill_i),
    .lost_beg_i  (lost_beg_i),
    .lost_mid_i  (lost_mid_i),
    .lost_end_i  (lost_end_i),
    .status_o    (status_w)
  );

  // register writes
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      user_id_r <= 8'h00;
      channel_r <= 8'h00;
      format_r  <= rhb_pkg::FMT_16BIT;
      serial_r  <= rhb_pkg::SERIAL_RST;
      period_r  <= rhb_pkg::ZERO32;
      gp_r      <= 16'h0000;
    end
    else if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        rhb_pkg::A_USER_ID: user_id_r <= reg_wdata_i[7:0]; // R2
        rhb_pkg::A_CHANNEL: channel_r <= reg_wdata_i[7:0]; // R3
        // only the two defined codes are accepted
        rhb_pkg::A_FORMAT:
          if (reg_wdata_i[7:0] == rhb_pkg::FMT_16BIT ||
              reg_wdata_i[7:0] == rhb_pkg::FMT_32BIT)
            format_r <= reg_wdata_i[7:0]; // R18
        rhb_pkg::A_SERIAL:
          serial_r <= 32'(reg_wdata_i[SERIAL_W-1:0]); // R4
        rhb_pkg::A_PERIOD:  period_r <= reg_wdata_i; // R6
        rhb_pkg::A_GP:      gp_r <= reg_wdata_i[15:0]; // R10
        default:            ;
      endcase
    end
  end

  // register reads, data one cycle later, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      reg_rdata_o <= rhb_pkg::ZERO32;
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        rhb_pkg::A_USER_ID: reg_rdata_o <= {24'h00_0000, user_id_r};
        rhb_pkg::A_CHANNEL: reg_rdata_o <= {24'h00_0000, channel_r};
        rhb_pkg::A_FORMAT:  reg_rdata_o <= {24'h00_0000, format_r};
        rhb_pkg::A_SERIAL:  reg_rdata_o <= serial_r;
        rhb_pkg::A_PERIOD:  reg_rdata_o <= period_r;
        rhb_pkg::A_GP:      reg_rdata_o <= {16'h0000, gp_r};
        rhb_pkg::A_RECCNT:  reg_rdata_o <= rec_cnt_r;
        rhb_pkg::A_STATUS:  reg_rdata_o <= {24'h00_0000, stat_hold_r};
        rhb_pkg::A_TSRST:   reg_rdata_o <= {16'h0000, ts_rst_cnt_r};
        default:            reg_rdata_o <= rhb_pkg::ZERO32;
      endcase
    end
    else
      reg_rdata_o <= rhb_pkg::ZERO32;
  end

  // record counter counts captures from reset
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      rec_cnt_r <= rhb_pkg::ZERO32;
    else if (rec_start_i)
      rec_cnt_r <= rec_cnt_r + rhb_pkg::CNT_ONE; // R5
  end

  // timestamp reset counter wraps at 16 bits
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      ts_rst_cnt_r <= 16'h0000;
    else if (ts_reset_i)
      ts_rst_cnt_r <= ts_rst_cnt_r + 16'h0001; // R11
  end

  // per-record timing captured at the start; length at the end
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      trig_time_field <= 64'h0000_0000_0000_0000;
      start_off_r     <= 64'h0000_0000_0000_0000;
      len_r           <= rhb_pkg::ZERO32;
    end
    else
    begin
      if (rec_start_i)
      begin
        trig_time_field <= trig_time_i; // R7
        start_off_r     <= start_off_i; // R8
      end
      if (rec_end_i)
        len_r <= rec_len_i; // R9
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      end_d_r <= 1'b0;
    else
      end_d_r <= rec_end_i;
  end

  // header word table, little-endian byte order
  function automatic logic [31:0] hdr_word(input logic [3:0] idx);
    logic [31:0] w;
    w = rhb_pkg::ZERO32;
    unique case (idx)
      4'h0: w = {format_r, channel_r, user_id_r, status_w}; // R1 R22
      4'h1: w = serial_r;
      4'h2: w = rec_cnt_r;
      4'h3: w = period_r;
      4'h4: w = trig_time_field[31:0];
      4'h5: w = trig_time_field[63:32];
      4'h6: w = start_off_r[31:0];
      4'h7: w = start_off_r[63:32];
      4'h8: w = len_r;
      4'h9: w = {ts_rst_cnt_r, gp_r};
      default: w = rhb_pkg::ZERO32;
    endcase
    return w;
  endfunction : hdr_word

  // header words are read live from the field registers; the next record start must follow its emission
  always_comb
  begin
    sending_nxt = 1'b0;
    word_nxt    = hdr_data_o;
    unique case (state_r)
      ST_IDLE:
      begin
        sending_nxt = end_d_r;
        word_nxt    = hdr_word(4'h0);
      end
      ST_SEND:
      begin
        sending_nxt = !(hdr_ready_i && widx_r == rhb_pkg::WIDX_LAST);
        word_nxt    = hdr_ready_i ? hdr_word(widx_r + 4'h1) : hdr_data_o;
      end
      default:
      begin
        sending_nxt = 1'b0;
        word_nxt    = rhb_pkg::ZERO32;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      state_r     <= ST_IDLE;
      widx_r      <= 4'h0;
      hdr_valid_o <= 1'b0;
      hdr_last_o  <= 1'b0;
      hdr_data_o  <= rhb_pkg::ZERO32;
      stat_hold_r <= 8'h00;
    end
    else
    begin
      hdr_data_o  <= word_nxt;
      hdr_valid_o <= sending_nxt;
      unique case (state_r)
        ST_IDLE:
          if (end_d_r)
          begin
            state_r     <= ST_SEND;
            widx_r      <= 4'h0;
            hdr_last_o  <= 1'b0;
            stat_hold_r <= status_w;
          end
        ST_SEND:
          if (hdr_ready_i)
          begin
            if (widx_r == rhb_pkg::WIDX_LAST)
            begin
              state_r     <= ST_IDLE;
              hdr_last_o  <= 1'b0;
            end
            else
            begin
              widx_r     <= widx_r + 4'h1; // R21
              hdr_last_o <= (widx_r + 4'h1) == rhb_pkg::WIDX_LAST;
            end
          end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  property p_valid_hold;
    @(posedge clk_i) disable iff (!nrst_i)
      (hdr_valid_o && !hdr_ready_i) |=> hdr_valid_o && $stable(hdr_data_o);
  endproperty
  a_valid_hold: assert property (p_valid_hold) // R22
    else $error("header word changed while stalled");

  // nine plain words split so no repetition count exceeds eight
  sequence s_nine_words;
    (hdr_valid_o && hdr_ready_i && !hdr_last_o)[*8]
      ##1 (hdr_valid_o && hdr_ready_i && !hdr_last_o);
  endsequence

  sequence s_ten_words;
    s_nine_words ##1 (hdr_valid_o && hdr_ready_i && hdr_last_o);
  endsequence

  property p_forty_bytes;
    @(posedge clk_i) disable iff (!nrst_i)
      ($rose(hdr_valid_o) && hdr_ready_i) ##0 s_ten_words |=> !hdr_valid_o;
  endproperty
  a_forty_bytes: assert property (p_forty_bytes) // R21
    else $error("header not ten words long");

  property p_last_word;
    @(posedge clk_i) disable iff (!nrst_i)
      hdr_last_o |-> hdr_valid_o && widx_r == rhb_pkg::WIDX_LAST;
  endproperty
  a_last_word: assert property (p_last_word) // R21
    else $error("last flag away from the tenth word");

  property p_len_capture;
    @(posedge clk_i) disable iff (!nrst_i)
      rec_end_i |=> len_r == $past(rec_len_i);
  endproperty
  a_len_capture: assert property (p_len_capture) // R9
    else $error("record length not captured at record end");

  property p_cnt_inc;
    @(posedge clk_i) disable iff (!nrst_i)
      rec_start_i |=> rec_cnt_r == $past(rec_cnt_r) + rhb_pkg::CNT_ONE;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) // R5
    else $error("record counter did not step");

  property p_first_word;
    @(posedge clk_i) disable iff (!nrst_i)
      $rose(hdr_valid_o) |-> hdr_data_o[15:8] == user_id_r &&
        hdr_data_o[23:16] == channel_r && hdr_data_o[31:24] == format_r;
  endproperty
  a_first_word: assert property (p_first_word) // R2
    else $error("first header word misplaced");

  property p_format_legal;
    @(posedge clk_i) disable iff (!nrst_i)
      format_r == rhb_pkg::FMT_16BIT || format_r == rhb_pkg::FMT_32BIT;
  endproperty
  a_format_legal: assert property (p_format_legal) // R18
    else $error("illegal data format code");
endmodule : rhb_top
`default_nettype wire

//--- tb_record_header_builder.sv
// testbench: register port, record events and emitted header contents
`default_nettype none
`define CHK(a, b) \
  begin \
    checks_done++; \
    if ((a) !== (b)) \
    begin \
      fail_count++; \
      $display("BAD %0t got %h want %h", $time, (a), (b)); \
    end \
  end
module tb_record_header_builder;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, nrst_i, reg_wr_i, reg_rd_i, rec_start_i, rec_end_i;
  logic range_evt_i, lost_beg_i, lost_mid_i, lost_end_i, ts_reset_i;
  logic hdr_valid_o, hdr_last_o, hdr_ready_i, stall, err;
  logic [3:0]   reg_addr_i;
  logic [31:0]  reg_wdata_i, reg_rdata_o, rec_len_i, hdr_data_o, d;
  logic [63:0]  trig_time_i, start_off_i;
  logic [2:0]   fill_i;
  logic [319:0] hdr;
  logic [7:0]   user, chan, fmt;
  logic [31:0]  serial, period, reccnt;
  logic [15:0]  gp, tsrst;
  int           n_hdr, fail_count, checks_done, seed;

  rhb_top #(.SERIAL_W(32)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .rec_start_i(rec_start_i), .rec_end_i(rec_end_i),
    .trig_time_i(trig_time_i), .start_off_i(start_off_i),
    .rec_len_i(rec_len_i), .range_evt_i(range_evt_i), .fill_i(fill_i),
    .lost_beg_i(lost_beg_i), .lost_mid_i(lost_mid_i),
    .lost_end_i(lost_end_i), .ts_reset_i(ts_reset_i),
    .hdr_data_o(hdr_data_o), .hdr_valid_o(hdr_valid_o),
    .hdr_last_o(hdr_last_o), .hdr_ready_i(hdr_ready_i));
  rhb_dma_sink i_dma (.clk_i(clk_i), .nrst_i(nrst_i),
    .hdr_data_i(hdr_data_o), .hdr_valid_i(hdr_valid_o),
    .hdr_last_i(hdr_last_o), .hdr_ready_o(hdr_ready_i), .stall_i(stall),
    .hdr_o(hdr), .n_hdr_o(n_hdr), .err_o(err));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [319:0] exp_hdr(input logic [7:0] st,
    input logic [63:0] tt, input logic [63:0] so, input logic [31:0] ln);
    exp_hdr = {tsrst, gp, ln, so, tt, period, reccnt, serial,
               fmt, chan, user, st};
  endfunction : exp_hdr

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_rd_i    <= 1'b0;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
  endtask : wr

  // every write series ends with a read, which drops the write strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    reg_addr_i <= a;
    reg_wr_i   <= 1'b0;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
    v = reg_rdata_o;
  endtask : rd

  // frc forces {end, mid, begin, range} in the first record cycle
  task automatic rec(input logic [3:0] frc, input bit rnd, input int n);
    logic [63:0] tt, so;
    logic [31:0] ln;
    logic [7:0]  st;
    logic [4:0]  ev;
    logic [2:0]  f;
    int          nh;
    tt = {$random(seed), $random(seed)};
    so = {$random(seed), $random(seed)};
    ln = $random(seed);
    st = 8'h00;
    nh = n_hdr;
    rec_start_i <= 1'b1;
    trig_time_i <= tt;
    start_off_i <= so;
    @(posedge clk_i);
    rec_start_i <= 1'b0;
    reccnt++;
    for (int i = 0; i <= n; i++)
    begin
      ev = rnd ? 5'($random(seed)) : 5'h00;
      f  = rnd ? 3'($random(seed)) : 3'h0;
      if (i == 0)
        ev[3:0] = ev[3:0] | frc;
      range_evt_i <= ev[0];
      lost_beg_i  <= ev[1];
      lost_mid_i  <= ev[2];
      lost_end_i  <= ev[3];
      ts_reset_i  <= ev[4];
      fill_i      <= f;
      rec_end_i   <= (i == n);
      rec_len_i   <= ln;
      st = st | {1'b0, ev[3:1], 3'h0, ev[0]};
      if (f > st[3:1])
        st[3:1] = f;
      tsrst = tsrst + 16'(ev[4]);
      @(posedge clk_i);
    end
    {rec_end_i, range_evt_i, lost_beg_i, lost_mid_i} <= 4'h0;
    {lost_end_i, ts_reset_i, fill_i} <= 5'h00;
    for (int k = 0; k < 200 && n_hdr == nh; k++)
    begin
      stall <= rnd && (($random(seed) & 3) == 0);
      @(posedge clk_i);
    end
    stall <= 1'b0;
    `CHK(n_hdr, nh + 1)
    `CHK(hdr[7:0], st)
    `CHK(hdr, exp_hdr(st, tt, so, ln))
    `CHK(err, 1'b0)
    rd(rhb_pkg::A_STATUS, d);
    `CHK(d, {24'h0000_00, st})
    rd(rhb_pkg::A_RECCNT, d);
    `CHK(d, reccnt)
    rd(rhb_pkg::A_TSRST, d);
    `CHK(d, {16'h0000, tsrst})
    $display("record %0d done", reccnt);
  endtask : rec

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    #400_000;
    fail_count++;
    conclude();
  end

  initial
  begin
    seed = 2573;
    {nrst_i, reg_wr_i, reg_rd_i, rec_start_i, rec_end_i} = 5'h00;
    {range_evt_i, lost_beg_i, lost_mid_i, lost_end_i} = 4'h0;
    {ts_reset_i, stall, reg_addr_i, fill_i} = 9'h000;
    {reg_wdata_i, rec_len_i, trig_time_i, start_off_i} = 192'h0;
    reccnt = 32'h0000_0000;
    tsrst  = 16'h0000;
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rd(rhb_pkg::A_FORMAT, d);
    `CHK(d, rhb_pkg::ZERO32)
    rd(rhb_pkg::A_SERIAL, d);
    `CHK(d, rhb_pkg::SERIAL_RST)
    rd(rhb_pkg::A_RECCNT, d);
    `CHK(d, rhb_pkg::ZERO32)
    user   = 8'($random(seed));
    chan   = 8'($random(seed));
    serial = $random(seed);
    period = $random(seed);
    gp     = 16'($random(seed));
    fmt    = rhb_pkg::FMT_32BIT;
    wr(rhb_pkg::A_USER_ID, {24'h0000_00, user});
    wr(rhb_pkg::A_CHANNEL, {24'h0000_00, chan});
    wr(rhb_pkg::A_FORMAT, {24'h0000_00, fmt});
    wr(rhb_pkg::A_SERIAL, serial);
    wr(rhb_pkg::A_PERIOD, period);
    wr(rhb_pkg::A_GP, {16'h0000, gp});
    // unsupported format codes and unmapped places must change nothing
    wr(rhb_pkg::A_FORMAT, 32'h0000_0002);
    wr(4'hC, 32'hFFFF_FFFF);
    rd(rhb_pkg::A_FORMAT, d);
    `CHK(d, {24'h0000_00, fmt})
    rd(4'hC, d);
    `CHK(d, rhb_pkg::ZERO32)
    rd(rhb_pkg::A_USER_ID, d);
    `CHK(d, {24'h0000_00, user})
    rd(rhb_pkg::A_CHANNEL, d);
    `CHK(d, {24'h0000_00, chan})
    rd(rhb_pkg::A_SERIAL, d);
    `CHK(d, serial)
    rd(rhb_pkg::A_PERIOD, d);
    `CHK(d, period)
    rd(rhb_pkg::A_GP, d);
    `CHK(d, {16'h0000, gp})
    $display("register test done");
    rec(4'b0001, 1'b0, 3);
    rec(4'b0000, 1'b0, 2);
    rec(4'b0010, 1'b1, 5);
    rec(4'b0100, 1'b1, 9);
    rec(4'b1000, 1'b1, 1);
    fmt = rhb_pkg::FMT_16BIT;
    wr(rhb_pkg::A_FORMAT, {24'h0000_00, fmt});
    rd(rhb_pkg::A_FORMAT, d);
    `CHK(d, {24'h0000_00, fmt})
    repeat (6)
      rec(4'b0000, 1'b1, 1 + ($unsigned($random(seed)) % 16));
    conclude();
  end
endmodule : tb_record_header_builder
`default_nettype wire
